// *** common/gls_consts.svh ***
// guard lock supervisor constants: offsets, fields, timing
// assumes a 20 MHz sys_clk and an axi4-lite register bus of 32 bits
// Function
// - with gate: status high only closed and locked
// - unlock request drops status immediately, starts unlock
// - wait release delay before energising the magnet
// - door open while locked is error, status low
// - feedback must follow drive within timeout
// - gate input used only when not gateless
// - gateless: request low drops drive same step
// - gateless: status high when feedback shows locked
// - with gate: drop drive only after gate closed
// - with gate: status high when locked and closed
// - spring hold: de-energised magnet means locked
// - magnet feedback reports energised state
// - high request unlocks, low request locks
// - fault flag high while error present if enabled (code holds it after the error until a fault clear write)
`ifndef GLS_CONSTS_SVH
`define GLS_CONSTS_SVH

`define GLS_CLK_HZ 20000000
`define GLS_UNLOCK_MS 500
`define GLS_FBK_MS 100
`define GLS_UNLOCK_CYC ((`GLS_UNLOCK_MS * (`GLS_CLK_HZ / 1000)))
`define GLS_FBK_CYC ((`GLS_FBK_MS * (`GLS_CLK_HZ / 1000)))

`define GLS_OFS_CTRL 12'h000
`define GLS_OFS_STAT 12'h004
`define GLS_OFS_IRQ_STAT 12'h008
`define GLS_OFS_IRQ_CLR 12'h00c
`define GLS_OFS_IRQ_EN 12'h010

`define GLS_CTRL_GATELESS 0
`define GLS_CTRL_SPRING 1
`define GLS_CTRL_ERR_EN 2
`define GLS_CTRL_FLT_CLR 3
`define GLS_CTRL_RST 32'h0000_0006

`define GLS_EV_UNLOCKED 0
`define GLS_EV_LOCKED 1
`define GLS_EV_FAULT 2
`define GLS_EV_W 3

`define GLS_RESP_OK 2'b00
`define GLS_RESP_ERR 2'b10

`endif

// *** common/gls_pkg.sv ***
// guard lock supervisor types shared by the top, the checker and the bench
// assumes gls_consts.svh is compiled alongside
package gls_pkg;
    typedef enum logic [2:0] {
        GLS_LOCKED,
        GLS_DELAY,
        GLS_UNLOCKED,
        GLS_WAIT_GATE,
        GLS_RELOCK
    } gls_state_e;

    // field inputs from the safety input elements
    typedef struct packed {
        logic release_req;
        logic gate_closed;
        logic magnet_energised;
    } gls_field_in_s;

    // configuration steering the supervisor
    typedef struct packed {
        logic gateless;
        logic spring_hold;
        logic err_en;
    } gls_cfg_s;
endpackage

// *** hdl/gls_timer.sv ***
// down counter with load and one-cycle expiry pulse
// assumes one clock domain and a synchronous reset copy
`timescale 1ns/1ps
module gls_timer #(
    parameter int W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic run,
    // status
    output logic expired
);
    logic [W-1:0] cnt_reg;

    // count while run, fire once when reaching zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            expired <= 1'b0;
        end else if (load) begin
            cnt_reg <= load_val;
            expired <= 1'b0;
        end else if (run && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
            expired <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
        end else begin
            expired <= 1'b0;
        end
    end
endmodule

// *** hdl/gls_top.sv ***
// guard lock supervisor: drives the lock magnet and locked status
// assumes field inputs synchronous to sys_clk, axi4-lite master
`timescale 1ns/1ps
`include "gls_consts.svh"
module gls_top #(
    parameter int UNLOCK_CYC = `GLS_UNLOCK_CYC,
    parameter int FBK_CYC = `GLS_FBK_CYC,
    parameter int TW = 24
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // field side
    input wire gls_pkg::gls_field_in_s field_in,
    output logic lock_drive,
    output logic closed_locked_status,
    output logic fault_flag,
    output logic irq,
    // axi4-lite write address
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    // axi4-lite write data
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // axi4-lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read address
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    // axi4-lite read data
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    import gls_pkg::*;

    logic rst_s1_reg, rst_n_reg;
    gls_state_e state_reg;
    logic [31:0] ctrl_reg;
    gls_cfg_s cfg;
    logic fault_reg;
    logic [`GLS_EV_W-1:0] ev_stat_reg, ev_en_reg, ev_set;
    logic [11:0] aw_reg;
    logic aw_have_reg, w_have_reg;
    logic [31:0] w_reg;
    logic w_lane0_reg;
    logic fbk_load, fbk_expired, dly_load, dly_expired;
    logic drive_next, drive_prev_reg, want_energised;
    logic magnet_locked, req, gate_ok, wr_fire, clr_pulse;

    // release reset through two flops so the exit is glitch free
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    assign cfg.gateless = ctrl_reg[`GLS_CTRL_GATELESS];
    assign cfg.spring_hold = ctrl_reg[`GLS_CTRL_SPRING];
    assign cfg.err_en = ctrl_reg[`GLS_CTRL_ERR_EN];

    // feedback is the energised state; locked polarity follows option
    assign magnet_locked = cfg.spring_hold ?
        !field_in.magnet_energised : field_in.magnet_energised;
    assign req = field_in.release_req;
    // gate only matters in with-gate mode
    assign gate_ok = cfg.gateless | field_in.gate_closed;

    // main sequence
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= GLS_LOCKED;
        end else begin
            unique case (state_reg)
                GLS_LOCKED: begin
                    if (req) begin
                        state_reg <= GLS_DELAY;
                    end
                end
                GLS_DELAY: begin
                    if (!req) begin
                        state_reg <= GLS_LOCKED;
                    end else if (dly_expired) begin
                        state_reg <= GLS_UNLOCKED;
                    end
                end
                GLS_UNLOCKED: begin
                    if (!req) begin
                        // relock at once when gateless or gate closed, else wait the gate
                        state_reg <= gate_ok ? GLS_RELOCK
                            : GLS_WAIT_GATE;
                    end
                end
                GLS_WAIT_GATE: begin
                    if (req) begin
                        state_reg <= GLS_UNLOCKED;
                    end else if (gate_ok) begin
                        state_reg <= GLS_RELOCK;
                    end
                end
                GLS_RELOCK: begin
                    if (req) begin
                        state_reg <= GLS_DELAY;
                    end else if (magnet_locked) begin
                        state_reg <= GLS_LOCKED;
                    end
                end
            endcase
        end
    end

    // drive energises to unlock under spring hold, to lock otherwise
    always_comb begin
        want_energised = (state_reg == GLS_UNLOCKED) ||
            (state_reg == GLS_WAIT_GATE) ||
            (state_reg == GLS_DELAY && dly_expired && req);
        drive_next = cfg.spring_hold ? want_energised : !want_energised;
        if (state_reg == GLS_UNLOCKED && !req && gate_ok) begin
            drive_next = !cfg.spring_hold;
        end
    end

    // drive output register, compared with previous for timer restart
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            lock_drive <= 1'b0;
            drive_prev_reg <= 1'b0;
        end else begin
            lock_drive <= drive_next;
            drive_prev_reg <= lock_drive;
        end
    end

    assign dly_load = (state_reg == GLS_LOCKED && req) ||
        (state_reg == GLS_RELOCK && req);
    // restart on every drive edge; stop once magnet follows
    assign fbk_load = lock_drive != drive_prev_reg;

    gls_timer #(.W(TW)) u_dly (
        .clk(sys_clk),
        .rst_n(rst_n_reg),
        .load(dly_load),
        .load_val(TW'(UNLOCK_CYC)),
        .run(state_reg == GLS_DELAY),
        .expired(dly_expired)
    );

    gls_timer #(.W(TW)) u_fbk (
        .clk(sys_clk),
        .rst_n(rst_n_reg),
        .load(fbk_load),
        .load_val(TW'(FBK_CYC)),
        .run(field_in.magnet_energised != lock_drive),
        .expired(fbk_expired)
    );

    // sticky fault; a new fault wins over software clear
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            fault_reg <= 1'b0;
        end else if (fbk_expired) begin
            fault_reg <= 1'b1;
        end else if (!cfg.gateless && state_reg == GLS_LOCKED &&
                     magnet_locked && !field_in.gate_closed) begin
            fault_reg <= 1'b1;
        end else if (clr_pulse) begin
            fault_reg <= 1'b0;
        end
    end

    // status and fault outputs straight from flops
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            closed_locked_status <= 1'b0;
            fault_flag <= 1'b0;
        end else begin
            closed_locked_status <= !req && !fault_reg &&
                magnet_locked && gate_ok &&
                (state_reg == GLS_LOCKED || state_reg == GLS_RELOCK);
            fault_flag <= cfg.err_en && fault_reg;
        end
    end

    assign ev_set[`GLS_EV_UNLOCKED] = fbk_load && state_reg == GLS_UNLOCKED;
    assign ev_set[`GLS_EV_LOCKED] = state_reg == GLS_RELOCK &&
        magnet_locked && !req;
    assign ev_set[`GLS_EV_FAULT] = fbk_expired;

    // write path: take address and data in either order
    assign wr_fire = aw_have_reg && w_have_reg && !s_bvalid;
    assign clr_pulse = wr_fire && aw_reg == `GLS_OFS_CTRL && w_lane0_reg &&
        w_reg[`GLS_CTRL_FLT_CLR];
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_reg <= '0;
            w_reg <= '0;
            w_lane0_reg <= 1'b0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= `GLS_RESP_OK;
        end else begin
            s_awready <= !aw_have_reg && !s_awready && !s_bvalid;
            s_wready <= !w_have_reg && !s_wready && !s_bvalid;
            if (s_awvalid && s_awready) begin
                aw_have_reg <= 1'b1;
                aw_reg <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_reg <= 1'b1;
                w_reg <= s_wdata;
                // strobe is only valid beside wvalid, so keep it with data
                w_lane0_reg <= s_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= (aw_reg == `GLS_OFS_CTRL ||
                    aw_reg == `GLS_OFS_IRQ_CLR ||
                    aw_reg == `GLS_OFS_IRQ_EN) ? `GLS_RESP_OK
                    : `GLS_RESP_ERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // writable registers; config changes take effect next cycle
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl_reg <= `GLS_CTRL_RST;
            ev_en_reg <= '0;
        end else if (wr_fire && w_lane0_reg) begin
            if (aw_reg == `GLS_OFS_CTRL) begin
                ctrl_reg <= {29'h0, w_reg[2:0]};
            end
            if (aw_reg == `GLS_OFS_IRQ_EN) begin
                ev_en_reg <= w_reg[`GLS_EV_W-1:0];
            end
        end
    end

    // sticky events; set beats clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ev_stat_reg <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_fire && w_lane0_reg && aw_reg == `GLS_OFS_IRQ_CLR) begin
                ev_stat_reg <= (ev_stat_reg & ~w_reg[`GLS_EV_W-1:0])
                    | ev_set;
            end else begin
                ev_stat_reg <= ev_stat_reg | ev_set;
            end
            irq <= |(ev_stat_reg & ev_en_reg);
        end
    end

    // read path: one read at a time, answer two cycles after address
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= `GLS_RESP_OK;
        end else begin
            s_arready <= !s_arready && !s_rvalid && s_arvalid;
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp <= `GLS_RESP_OK;
                unique case (s_araddr)
                    `GLS_OFS_CTRL: s_rdata <= ctrl_reg;
                    `GLS_OFS_STAT: s_rdata <= {24'h0, fault_reg,
                        lock_drive, closed_locked_status,
                        field_in.magnet_energised, field_in.gate_closed,
                        state_reg};
                    `GLS_OFS_IRQ_STAT: s_rdata <= {29'h0, ev_stat_reg};
                    `GLS_OFS_IRQ_EN: s_rdata <= {29'h0, ev_en_reg};
                    default: begin
                        s_rdata <= '0;
                        s_rresp <= `GLS_RESP_ERR;
                    end
                endcase
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end
endmodule

// *** dv/gls_chk.sv ***
// checker: port timing of the guard lock supervisor
// assumes err_en set whenever the magnet lags; spring hold polarity, drive high unlocks
`timescale 1ns/1ps
module gls_chk #(
    parameter int UNLOCK_CYC = 20,
    parameter int FBK_CYC = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // field side
    input wire gls_pkg::gls_field_in_s field_in,
    input wire logic lock_drive,
    input wire logic closed_locked_status,
    input wire logic fault_flag,
    // bus answers
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid,
    input wire logic s_rready
);
    import gls_pkg::*;
    logic [31:0] req_cnt;
    logic [7:0] fbk_cnt;
    logic drive_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // cycles the unlock request has been held, wide for the full delay
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) req_cnt <= 32'h0;
        else if (!field_in.release_req) req_cnt <= 32'h0;
        else if (req_cnt != 32'hffff_ffff) req_cnt <= req_cnt + 32'h1;
    end
    // last drive level, to see each drive change
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) drive_q <= 1'b0;
        else drive_q <= lock_drive;
    end
    // feedback lag, restarted on every drive change
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) fbk_cnt <= 8'h00;
        else if (lock_drive != drive_q) fbk_cnt <= 8'h00;
        else if (field_in.magnet_energised == lock_drive) fbk_cnt <= 8'h00;
        else if (fbk_cnt != 8'hff) fbk_cnt <= fbk_cnt + 8'h01;
    end
    // request from the de-energised rest state only
    sequence s_unlock_req;
        $rose(field_in.release_req) && !lock_drive;
    endsequence
    sequence s_door_open;
        !field_in.gate_closed ##1 !field_in.gate_closed;
    endsequence
    chk_status_drop: assert property (
        field_in.release_req |=> !closed_locked_status)
        else $error("status high during unlock request");
    chk_unlock_hold: assert property (
        s_unlock_req |=> !lock_drive [*8])
        else $error("magnet energised too early");
    chk_unlock_delay: assert property (
        $rose(lock_drive) && field_in.release_req |->
        req_cnt >= UNLOCK_CYC - 1)
        else $error("unlock delay cut short");
    chk_relock_gate: assert property (
        $fell(lock_drive) |-> $past(field_in.gate_closed))
        else $error("relocked with gate open");
    chk_relock_prompt: assert property (
        $fell(field_in.release_req) && field_in.gate_closed && lock_drive
        |=> !lock_drive)
        else $error("drive kept after request dropped");
    chk_status_cause: assert property (
        $rose(closed_locked_status) |->
        $past(field_in.magnet_energised) == $past(lock_drive)
        && $past(field_in.gate_closed))
        else $error("status rose while not locked");
    chk_door_open: assert property (
        s_door_open |-> !closed_locked_status)
        else $error("status high with door open");
    chk_fbk_timeout: assert property (
        fbk_cnt == FBK_CYC + 3 |-> fault_flag)
        else $error("feedback timeout not flagged");
    chk_bresp_hold: assert property (
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped early");
endmodule

bind gls_top gls_chk #(.UNLOCK_CYC(UNLOCK_CYC), .FBK_CYC(FBK_CYC))
    gls_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n), .field_in(field_in),
    .lock_drive(lock_drive), .closed_locked_status(closed_locked_status),
    .fault_flag(fault_flag), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_rdata(s_rdata), .s_rvalid(s_rvalid),
    .s_rready(s_rready));

// *** dv/gls_lock_model.sv ***
// lock model: electromagnet with feedback contact and settable lag
// assumes drive high energises the coil; lag in sys_clk cycles
`timescale 1ns/1ps
module gls_lock_model (
    // clock
    input wire logic sys_clk,
    // coil side
    input wire logic lock_drive,
    input wire logic [7:0] lag,
    // feedback contact
    output logic magnet_energised
);
    logic [7:0] cnt;
    initial magnet_energised = 1'b0;
    initial cnt = 8'h00;
    // coil follows its drive only after the mechanical lag
    always @(posedge sys_clk) begin
        if (lock_drive == magnet_energised) cnt <= 8'h00;
        else if (cnt >= lag) begin
            magnet_energised <= lock_drive;
            cnt <= 8'h00;
        end
        else cnt <= cnt + 8'h01;
    end
endmodule

// *** dv/testbench.sv ***
// bench: drives unlock cycles and the register bus of gls_top
// assumes short timers, 20 for unlock and 8 for feedback
`timescale 1ns/1ps
`include "gls_consts.svh"
module testbench;
    import gls_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n, req, gate, mag, drive, status, fault, irq;
    logic awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [1:0] bresp, rresp;
    logic [7:0] lag;
    gls_field_in_s field_in;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    assign field_in = {req, gate, mag};
    always #25 sys_clk = ~sys_clk;
    gls_top #(.UNLOCK_CYC(20), .FBK_CYC(8)) gls_top_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .field_in(field_in),
        .lock_drive(drive), .closed_locked_status(status),
        .fault_flag(fault), .irq(irq), .s_awaddr(awa), .s_awvalid(awv),
        .s_awready(awr), .s_wdata(wd), .s_wstrb(4'hf), .s_wvalid(wv),
        .s_wready(wr_rdy), .s_bresp(bresp), .s_bvalid(bv),
        .s_bready(br), .s_araddr(ara), .s_arvalid(arv), .s_arready(arr),
        .s_rdata(rdat), .s_rresp(rresp), .s_rvalid(rv), .s_rready(rr));
    gls_lock_model gls_lock_model_inst (.sys_clk(sys_clk),
        .lock_drive(drive), .lag(lag), .magnet_energised(mag));
    task automatic final_report();
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic check(input string nm, input logic [31:0] s,
                         input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // poll one output for a level, bounded so a stuck design ends
    task automatic wait_for(input int sel, input logic v);
        for (int i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            if ((sel == 0 ? drive : status) === v) break;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge sys_clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, r});
    endtask
    // read and compare the bits kept by mask m
    task automatic rd(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] r);
        @(posedge sys_clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rr <= 1'b0;
        check("rdata", rdat & m, e);
        check("rresp", {30'h0, rresp}, {30'h0, r});
    endtask
    initial begin
        {rst_n, req, awv, wv, br, arv, rr, awa, ara, wd} = '0;
        gate = 1'b1;
        lag = 8'h03;
        cyc(8);
        rst_n <= 1'b1;
        cyc(4);
        rd(`GLS_OFS_CTRL, 32'hf, `GLS_CTRL_RST, `GLS_RESP_OK);
        rd(`GLS_OFS_IRQ_STAT, 32'h7, 32'h0, `GLS_RESP_OK);
        rd(12'h0f0, 32'hffff_ffff, 32'h0, `GLS_RESP_ERR);
        wr(`GLS_OFS_STAT, 32'h0, `GLS_RESP_ERR);
        wr(`GLS_OFS_IRQ_STAT, 32'h0, `GLS_RESP_ERR);
        check("status", status, 1'b1);
        wr(`GLS_OFS_IRQ_EN, 32'h7, `GLS_RESP_OK);
        // with gate: unlock, open, release while open, close
        req <= 1'b1;
        cyc(3);
        check("status", status, 1'b0);
        cyc(14);
        check("drive", drive, 1'b0);
        wait_for(0, 1'b1);
        check("drive", drive, 1'b1);
        cyc(8);
        check("irq", irq, 1'b1);
        rd(`GLS_OFS_IRQ_STAT, 32'h1, 32'h1, `GLS_RESP_OK);
        wr(`GLS_OFS_IRQ_EN, 32'h0, `GLS_RESP_OK);
        cyc(2);
        check("irq", irq, 1'b0);
        wr(`GLS_OFS_IRQ_EN, 32'h7, `GLS_RESP_OK);
        wr(`GLS_OFS_IRQ_CLR, 32'h7, `GLS_RESP_OK);
        cyc(2);
        check("irq", irq, 1'b0);
        gate <= 1'b0;
        req <= 1'b0;
        cyc(6);
        check("drive", drive, 1'b1);
        check("fault", fault, 1'b0);
        gate <= 1'b1;
        wait_for(0, 1'b0);
        wait_for(1, 1'b1);
        check("status", status, 1'b1);
        check("fault", fault, 1'b0);
        // door forced open while locked
        gate <= 1'b0;
        cyc(3);
        check("status", status, 1'b0);
        check("fault", fault, 1'b1);
        gate <= 1'b1;
        wr(`GLS_OFS_CTRL, 32'he, `GLS_RESP_OK);
        cyc(2);
        check("fault", fault, 1'b0);
        // gateless: drive drops at once when request falls
        wr(`GLS_OFS_CTRL, 32'h7, `GLS_RESP_OK);
        req <= 1'b1;
        wait_for(0, 1'b1);
        cyc(6);
        req <= 1'b0;
        cyc(2);
        check("drive", drive, 1'b0);
        wait_for(1, 1'b1);
        check("status", status, 1'b1);
        // no spring hold: the energised coil is what holds the lock
        wr(`GLS_OFS_CTRL, 32'h4, `GLS_RESP_OK);
        wait_for(0, 1'b1);
        check("drive", drive, 1'b1);
        wait_for(1, 1'b1);
        check("status", status, 1'b1);
        // slow magnet: feedback timeout
        wr(`GLS_OFS_CTRL, 32'h6, `GLS_RESP_OK);
        wait_for(1, 1'b1);
        check("drive", drive, 1'b0);
        lag <= 8'h1e;
        req <= 1'b1;
        wait_for(0, 1'b1);
        cyc(12);
        check("fault", fault, 1'b1);
        rd(`GLS_OFS_IRQ_STAT, 32'h4, 32'h4, `GLS_RESP_OK);
        lag <= 8'h03;
        req <= 1'b0;
        wait_for(0, 1'b0);
        cyc(8);
        check("status", status, 1'b0);
        // second reset in mid-run
        rst_n <= 1'b0;
        cyc(2);
        check("fault", fault, 1'b0);
        rst_n <= 1'b1;
        cyc(4);
        rd(`GLS_OFS_CTRL, 32'hf, `GLS_CTRL_RST, `GLS_RESP_OK);
        final_report();
    end
endmodule
